// ==== rtl/wwd_pkg.sv ====
// constants and types for the window watchdog
// Contract
// - counter ticks only from low-speed clock
// - oscillator runs if enabled or wakeup-select set
// - standby stops oscillator and counter when configured
// - after standby with standby-run off, counter restarts from zero
// - standby-run off forces fully open window
// - standby-run on keeps counting through standby
// - counter overflow raises internal reset
// - single-bit write to restart raises reset
// - restart byte other than ac raises reset
// - restart write in closed window resets
// - watchdog reset clears counter to zero
// - watchdog reset sets cause flag bit 4
// - option byte fetched at c0 after reset
// - boot swap fetches option from 10c0
// - optional interrupt at 75 percent elapsed
// - window code: 50, 75, 100 percent open
// - enable bit decides counting after reset
// - three-bit select gives eight overflow periods
// - option settings act only after release
// - first restart after reset ignores window
// - early restart resets; open period accepts
package wwd_pkg;
    // clock and low-speed oscillator timing
    localparam int CORE_FREQ_KHZ  = 100000;
    localparam int LSC_FREQ_KHZ   = 15;
    localparam int LSC_DIV_CYCLES = (CORE_FREQ_KHZ + LSC_FREQ_KHZ / 2) / LSC_FREQ_KHZ;
    // register bus
    localparam int           ADDR_W        = 8;
    localparam int           DATA_W        = 8;
    localparam logic [7:0]   ADR_RESTART   = 8'h04;
    localparam logic [7:0]   ADR_CAUSE     = 8'h08;
    localparam logic [7:0]   ADR_SPEED_CTL = 8'h0c;
    localparam logic [7:0]   ADR_STATUS    = 8'h10;
    localparam logic [7:0]   ADR_OPTION    = 8'hc0;
    localparam logic [7:0]   RESTART_KEY   = 8'hac;
    localparam int           CAUSE_BIT     = 4;
    localparam int           WAKE_SEL_BIT  = 4;
    // option byte fetch
    localparam int           OPT_AW        = 17;
    localparam logic [16:0]  OPT_BASE      = 17'h000c0;
    localparam logic [16:0]  OPT_BASE_SWAP = 17'h010c0;
    // option byte fields
    localparam int           OB_IRQ        = 7;
    localparam int           OB_WIN_HI     = 6;
    localparam int           OB_WIN_LO     = 5;
    localparam int           OB_EN         = 4;
    localparam int           OB_OVF_HI     = 3;
    localparam int           OB_OVF_LO     = 1;
    localparam int           OB_STBY       = 0;
    // window codes
    localparam logic [1:0]   WIN_50        = 2'h1;
    localparam logic [1:0]   WIN_75        = 2'h2;
    // counter
    localparam int           CNT_W         = 17;
    typedef logic [CNT_W-1:0] wwd_cnt_t;
    // overflow period as a power of two of low-speed clocks, per select code
    typedef logic [4:0] wwd_exp_t;
    localparam wwd_exp_t OVF_EXP [8] = '{5'h06, 5'h07, 5'h08, 5'h09,
                                         5'h0b, 5'h0d, 5'h0e, 5'h10};
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_WAIT  = 2'b01,
        ST_RUN   = 2'b10
    } wwd_state_e;
endpackage : wwd_pkg

// ==== rtl/wwd_core.sv ====
// window watchdog core: option fetch, low-speed tick, window counter, reset cause
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module wwd_core
    import wwd_pkg::*;
#(
    parameter int LSC_DIV = wwd_pkg::LSC_DIV_CYCLES
)(
    // clock and reset
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_B,
    // register port
    input  wire logic [wwd_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [wwd_pkg::DATA_W-1:0] WDATA,
    input  wire logic                      WR,
    input  wire logic                      BIT_OP,
    input  wire logic                      RD,
    output logic      [wwd_pkg::DATA_W-1:0] RDATA,
    // option byte fetch
    input  wire logic                      BOOT_SWAP,
    output logic                           OPT_RD,
    output logic      [wwd_pkg::OPT_AW-1:0] OPT_ADDR,
    input  wire logic [7:0]                OPT_DATA,
    // cpu standby state
    input  wire logic                      STANDBY,
    // outputs
    output logic                           LSC_RUN,
    output logic                           QUARTER_LEFT_IRQ,
    output logic                           GUARD_RESET
);
    import wwd_pkg::*;

    initial begin
        if (LSC_DIV < 2)
        begin
            $error("LSC_DIV must be at least 2");
        end
    end

    wwd_state_e              state_r;
    logic [7:0]              opt_r;
    logic                    first_done_r;
    logic                    cause_r;
    logic                    wake_sel_r;
    logic                    stopped_r;
    logic [31:0]             div_r;
    logic                    tick;
    wwd_cnt_t                cnt_r;
    wwd_cnt_t                period;
    wwd_cnt_t                closed_lim;
    logic                    quarter_left_irq_enable;
    logic [1:0]              open_window_sel;
    logic                    guard_counter_enable;
    logic [2:0]              overflow_sel;
    logic                    standby_run_option;
    logic                    running;
    logic                    hold;
    logic                    closed;
    logic                    wr_restart;
    logic                    bad_write;
    logic                    good_write;
    logic                    overflow;
    logic                    fault;
    logic                    osc_on;

    // option fields, only meaningful in run state
    assign quarter_left_irq_enable = opt_r[OB_IRQ];
    assign open_window_sel         = opt_r[OB_WIN_HI:OB_WIN_LO];
    assign guard_counter_enable    = opt_r[OB_EN];
    assign overflow_sel            = opt_r[OB_OVF_HI:OB_OVF_LO];
    assign standby_run_option      = opt_r[OB_STBY];

    assign period  = wwd_cnt_t'(1) << OVF_EXP[overflow_sel];

    // closed part of the period, measured from its start
    always_comb
    begin
        closed_lim = '0;
        if (!standby_run_option)
        begin
            closed_lim = '0;
        end
        else if (open_window_sel == WIN_50)
        begin
            closed_lim = period >> 1;
        end
        else if (open_window_sel == WIN_75)
        begin
            closed_lim = period >> 2;
        end
    end

    // first restart after release is free of the window
    assign closed = first_done_r && (cnt_r < closed_lim);

    assign running = (state_r == ST_RUN) && guard_counter_enable;
    // counter holds in standby unless standby-run is set
    assign hold    = STANDBY && !standby_run_option;
    // oscillator stops only when nothing else needs it
    assign osc_on  = (state_r == ST_RUN) && (guard_counter_enable || wake_sel_r)
                     && !(hold && !wake_sel_r);

    assign wr_restart = WR && (ADDR == ADR_RESTART) && (state_r == ST_RUN);
    assign bad_write  = wr_restart && (BIT_OP
                                    || (WDATA != RESTART_KEY)
                                    || closed);
    assign good_write = wr_restart && !bad_write;
    assign overflow   = running && !hold && tick && (cnt_r == period - wwd_cnt_t'(1));
    assign fault      = running && (bad_write || overflow);

    // option fetch after every reset, power-on or watchdog
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r  <= ST_FETCH;
            opt_r    <= 8'h00;
            OPT_RD   <= 1'b0;
            OPT_ADDR <= '0;
        end
        else if (fault)
        begin
            state_r  <= ST_FETCH;
            OPT_RD   <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_FETCH:
                begin
                    OPT_RD   <= 1'b1;
                    OPT_ADDR <= BOOT_SWAP ? OPT_BASE_SWAP : OPT_BASE;
                    state_r  <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    OPT_RD  <= 1'b0;
                    opt_r   <= OPT_DATA;
                    state_r <= ST_RUN;
                end
                ST_RUN:
                begin
                    OPT_RD <= 1'b0;
                end
                default:
                begin
                    state_r <= ST_FETCH;
                end
            endcase
        end
    end

    // low-speed clock stand-in: one-cycle tick per oscillator period
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            div_r   <= '0;
            LSC_RUN <= 1'b0;
        end
        else
        begin
            LSC_RUN <= osc_on;
            if (!osc_on || div_r == 32'(LSC_DIV - 1))
            begin
                div_r <= '0;
            end
            else
            begin
                div_r <= div_r + 32'h1;
            end
        end
    end
    assign tick = osc_on && (div_r == 32'(LSC_DIV - 1));

    // window counter
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cnt_r     <= '0;
            stopped_r <= 1'b0;
        end
        else
        begin
            stopped_r <= running && hold;
            if (!running || fault)
            begin
                cnt_r <= '0;
            end
            else if (good_write)
            begin
                cnt_r <= '0;
            end
            else if (stopped_r && !hold)
            begin
                cnt_r <= '0;
            end
            else if (tick && !hold)
            begin
                cnt_r <= cnt_r + wwd_cnt_t'(1);
            end
        end
    end

    // first-restart flag, reset pulse, quarter-left interrupt
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            first_done_r     <= 1'b0;
            GUARD_RESET      <= 1'b0;
            QUARTER_LEFT_IRQ <= 1'b0;
        end
        else
        begin
            GUARD_RESET      <= fault;
            QUARTER_LEFT_IRQ <= running && !hold && tick && quarter_left_irq_enable
                                && (cnt_r + wwd_cnt_t'(1) == period - (period >> 2));
            if (fault)
            begin
                first_done_r <= 1'b0;
            end
            else if (good_write)
            begin
                first_done_r <= 1'b1;
            end
        end
    end

    // software registers; cause flag survives the watchdog's own reset
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cause_r    <= 1'b0;
            wake_sel_r <= 1'b0;
        end
        else
        begin
            if (fault)
            begin
                cause_r <= 1'b1;
            end
            else if (RD && ADDR == ADR_CAUSE)
            begin
                cause_r <= 1'b0;
            end
            if (WR && ADDR == ADR_SPEED_CTL)
            begin
                wake_sel_r <= WDATA[WAKE_SEL_BIT];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            RDATA <= '0;
        end
        else if (RD)
        begin
            if (ADDR == ADR_CAUSE)
            begin
                RDATA <= DATA_W'(cause_r) << CAUSE_BIT;
            end
            else if (ADDR == ADR_SPEED_CTL)
            begin
                RDATA <= DATA_W'(wake_sel_r) << WAKE_SEL_BIT;
            end
            else if (ADDR == ADR_STATUS)
            begin
                RDATA <= {4'h0, stopped_r, first_done_r, !closed, running};
            end
            else if (ADDR == ADR_OPTION)
            begin
                RDATA <= opt_r;
            end
            else
            begin
                RDATA <= '0;
            end
        end
        else
        begin
            RDATA <= '0;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    a_ovf_reset:     assert property (overflow |=> GUARD_RESET ##1 !GUARD_RESET)
        else $error("overflow did not give one reset pulse");
    a_bitop_reset:   assert property (wr_restart && BIT_OP && running |=> GUARD_RESET)
        else $error("single-bit write did not reset");
    a_bad_key:       assert property (wr_restart && WDATA != RESTART_KEY && running |=> GUARD_RESET)
        else $error("wrong key did not reset");
    a_closed_write:  assert property (wr_restart && closed && running |=> GUARD_RESET)
        else $error("closed-window write did not reset");
    a_reset_clears:  assert property (GUARD_RESET |-> cnt_r == '0 && state_r != ST_RUN)
        else $error("counter not cleared on watchdog reset");
    a_cause_set:     assert property (GUARD_RESET |-> cause_r)
        else $error("cause flag not set");
    a_irq_gate:      assert property (QUARTER_LEFT_IRQ |-> quarter_left_irq_enable && $past(running))
        else $error("interrupt without option");
    a_stop_hold:     assert property (running && hold && $past(running && hold) |-> $stable(cnt_r))
        else $error("counter moved while stopped");
    a_wake_zero:     assert property (running && $past(stopped_r) && !$past(hold) |-> cnt_r == '0)
        else $error("counter not zero after standby");
    a_good_restart:  assert property (good_write && running |=> (cnt_r == '0 && !GUARD_RESET) ##1 !GUARD_RESET)
        else $error("valid restart mishandled");
    a_disabled_idle: assert property (state_r == ST_RUN && !guard_counter_enable |-> cnt_r == '0 && !GUARD_RESET)
        else $error("disabled counter moved");

    c_overflow:  cover property (overflow ##1 GUARD_RESET);
    c_restart:   cover property (good_write && first_done_r);
    c_irq:       cover property (QUARTER_LEFT_IRQ);
    c_standby:   cover property (stopped_r ##1 !hold);
endmodule : wwd_core
`default_nettype wire

// ==== verification/tb_window_watchdog_timer.sv ====
// self-checking testbench for the window watchdog core
`timescale 1ns/1ns
`default_nettype none
module tb_window_watchdog_timer;
    import wwd_pkg::*;
    logic                  core_clk = 1'b0;
    logic                  rst_b    = 1'b0;
    logic [ADDR_W-1:0]     addr     = '0;
    logic [DATA_W-1:0]     wdata    = '0;
    logic                  wr       = 1'b0;
    logic                  bit_op   = 1'b0;
    logic                  rd       = 1'b0;
    logic [DATA_W-1:0]     rdata;
    logic                  boot_swap = 1'b0;
    logic                  opt_rd;
    logic [OPT_AW-1:0]     opt_addr;
    logic [7:0]            opt_val  = 8'h00;
    logic                  standby  = 1'b0;
    logic                  lsc_run;
    logic                  irq;
    logic                  guard_reset;
    int                    num_errors = 0;
    int                    checks     = 0;
    int                    cycles     = 0;
    int                    irq_cnt    = 0;
    int                    n;
    logic [7:0]            d;

    // small divider keeps the shortest period at 64 ticks of 4 cycles
    wwd_core #(.LSC_DIV(4)) u_wwd_core (
        .CORE_CLK         (core_clk),
        .RST_B            (rst_b),
        .ADDR             (addr),
        .WDATA            (wdata),
        .WR               (wr),
        .BIT_OP           (bit_op),
        .RD               (rd),
        .RDATA            (rdata),
        .BOOT_SWAP        (boot_swap),
        .OPT_RD           (opt_rd),
        .OPT_ADDR         (opt_addr),
        .OPT_DATA         (opt_val),
        .STANDBY          (standby),
        .LSC_RUN          (lsc_run),
        .QUARTER_LEFT_IRQ (irq),
        .GUARD_RESET      (guard_reset)
    );

    always #5 core_clk = ~core_clk;

    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int lo, input int hi, input string msg);
        checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("[FAIL] %0t %s took %0d cycles", $time, msg, got);
        end
    endtask : chk_cnt

    always @(posedge core_clk)
    begin
        cycles++;
        if (irq === 1'b1)
            irq_cnt++;
        if (opt_rd === 1'b1)
            chk_val(opt_addr[7:0] ^ (boot_swap ? 8'h00 : 8'h00), 8'hc0, "fetch low");
        if (opt_rd === 1'b1)
            chk_val({7'h00, opt_addr[12]}, {7'h00, boot_swap}, "fetch base");
        if (cycles == 20000)
        begin
            num_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end

    task automatic do_reset(input logic [7:0] opt, input logic swap);
        @(posedge core_clk);
        rst_b     <= 1'b0;
        opt_val   <= opt;
        boot_swap <= swap;
        standby   <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b     <= 1'b1;
        irq_cnt = 0;
    endtask : do_reset

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v, input logic bop);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= v;
        bit_op <= bop;
        wr     <= 1'b1;
        @(posedge core_clk);
        wr     <= 1'b0;
        bit_op <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // cycles until the internal reset pulse shows, or max if it never does
    task automatic run_until(input int max, output int cnt);
        cnt = 0;
        while (guard_reset !== 1'b1 && cnt < max)
        begin
            @(posedge core_clk);
            #1 cnt++;
        end
    endtask : run_until

    task automatic t_overflow_and_faults;
        do_reset(8'hf1, 1'b1);
        run_until(400, n);
        chk_cnt(n, 245, 270, "overflow");
        chk_val(irq_cnt[7:0], 8'h01, "quarter irq");
        repeat (6) @(posedge core_clk);
        wr_reg(ADR_RESTART, 8'h55, 1'b0);
        run_until(2, n);
        chk_cnt(n, 0, 0, "bad key");
        repeat (6) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b1);
        run_until(2, n);
        chk_cnt(n, 0, 0, "bit write");
        rd_reg(ADR_CAUSE, d);
        chk_val(d, 8'h10, "cause set");
        rd_reg(ADR_CAUSE, d);
        chk_val(d, 8'h00, "cause cleared by read");
        rd_reg(ADR_OPTION, d);
        chk_val(d, 8'hf1, "option readback");
        rd_reg(8'h20, d);
        chk_val(d, 8'h00, "unmapped read");
    endtask : t_overflow_and_faults

    task automatic t_window;
        do_reset(8'h31, 1'b0);
        repeat (5) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        run_until(3, n);
        chk_cnt(n, 3, 3, "first restart free");
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        run_until(2, n);
        chk_cnt(n, 0, 0, "closed window restart");
        repeat (6) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        repeat (160) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        // no clear would overflow some 90 cycles from here
        run_until(400, n);
        chk_cnt(n, 245, 266, "open restart clears count");
    endtask : t_window

    task automatic t_disabled;
        do_reset(8'h61, 1'b0);
        run_until(600, n);
        chk_cnt(n, 600, 600, "disabled never fires");
        chk_val({7'h00, lsc_run}, 8'h00, "osc off");
        wr_reg(ADR_SPEED_CTL, 8'h10, 1'b0);
        repeat (3) @(posedge core_clk);
        #1 chk_val({7'h00, lsc_run}, 8'h01, "osc on by wake select");
        wr_reg(ADR_SPEED_CTL, 8'h00, 1'b0);
    endtask : t_disabled

    task automatic t_standby_stop;
        do_reset(8'h30, 1'b0);
        repeat (5) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        run_until(3, n);
        chk_cnt(n, 3, 3, "window forced open");
        @(posedge core_clk);
        standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk_val({7'h00, lsc_run}, 8'h00, "osc stops in standby");
        run_until(400, n);
        chk_cnt(n, 400, 400, "counter held in standby");
        @(posedge core_clk);
        standby <= 1'b0;
        run_until(400, n);
        chk_cnt(n, 254, 258, "count from zero after standby");
    endtask : t_standby_stop

    // 75 percent open: first quarter of the period is closed
    task automatic t_window75;
        do_reset(8'h51, 1'b0);
        repeat (5) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        repeat (40) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        run_until(2, n);
        chk_cnt(n, 0, 0, "restart in closed quarter");
        repeat (6) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        repeat (80) @(posedge core_clk);
        wr_reg(ADR_RESTART, RESTART_KEY, 1'b0);
        run_until(3, n);
        chk_cnt(n, 3, 3, "restart in open part");
        rd_reg(ADR_STATUS, d);
        chk_val(d, 8'h05, "status after restart");
    endtask : t_window75

    task automatic t_standby_run;
        do_reset(8'h71, 1'b0);
        standby <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chk_val({7'h00, lsc_run}, 8'h01, "osc runs in standby");
        run_until(400, n);
        chk_cnt(n, 235, 262, "overflow in standby");
        chk_val(irq_cnt[7:0], 8'h00, "no quarter irq");
    endtask : t_standby_run

    initial
    begin
        t_overflow_and_faults();
        t_window();
        t_disabled();
        t_standby_stop();
        t_standby_run();
        t_window75();
        give_verdict();
    end
endmodule : tb_window_watchdog_timer
`default_nettype wire
